/* File: verilog/afd_out_pkg.sv */
`default_nettype none
package fault_out_pkg;
    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int unsigned CLK_HZ        = 125_000_000;
    localparam int unsigned TICK_MS       = 1;
    localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned WIDTH_BITS    = 8;
    localparam int unsigned PERIOD_MS     = 255;
    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic        FLAG_RST      = 1'b0;
    localparam logic        PULSE_RST     = 1'b0;
    localparam logic        HALT_LVL_DEF  = 1'b0;
    typedef enum logic [1:0] {
        ST_RUN  = 2'b00,
        ST_TRY  = 2'b01,
        ST_DEAD = 2'b10
    } health_t;
endpackage
`default_nettype wire

/* File: verilog/feature_pulse_gen.sv */
`default_nettype none
module feature_pulse_gen
    import fault_out_pkg::*;
#(
    parameter int unsigned CYC_MS = CYC_PER_MS,
    parameter int unsigned W      = WIDTH_BITS,
    parameter logic [W-1:0] PER   = W'(PERIOD_MS)
) (
    input  wire logic         i_clk_sys,
    input  wire logic         i_nrst,
    input  wire logic [W-1:0] i_width_ms,
    input  wire logic         i_halt,
    input  wire logic         i_halt_lvl,
    output logic              o_pulse
);
    localparam int unsigned CW = $clog2(CYC_MS + 1);
    localparam logic [CW-1:0] CYC_LAST = CW'(CYC_MS - 1);

    logic [CW-1:0] cyc_q;
    logic          tick;
    logic [W-1:0]  ms_q;
    logic [W-1:0]  wid_q;

    assign tick = (cyc_q == CYC_LAST);

    // ****************************************************************
    // Millisecond timebase
    // ****************************************************************
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            cyc_q <= '0;
        end else if (tick) begin
            cyc_q <= '0;
        end else begin
            cyc_q <= cyc_q + 1'b1;
        end
    end

    // Width is only sampled at the period start to avoid runt pulses
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            ms_q  <= '0;
            wid_q <= '0;
        end else if (tick) begin
            if (ms_q == PER - 1'b1) begin
                ms_q  <= '0;
                wid_q <= i_width_ms;
            end else begin
                ms_q <= ms_q + 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_pulse <= PULSE_RST;
        end else if (i_halt) begin
            o_pulse <= i_halt_lvl;
        end else begin
            o_pulse <= (ms_q < wid_q);
        end
    end

    property p_halt_static;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        i_halt ##1 i_halt |-> o_pulse == $past(i_halt_lvl);
    endproperty
    a_halt_static: assert property (p_halt_static)
        else $error("feature pulse not static while halted");

    property p_tick_period;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        tick |=> !tick;
    endproperty
    a_tick_period: assert property (p_tick_period)
        else $error("ms tick repeated");

    property p_pulse_width;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        !i_halt |=> o_pulse == ($past(ms_q) < $past(wid_q));
    endproperty
    a_pulse_width: assert property (p_pulse_width)
        else $error("pulse level disagrees with ms count");
endmodule
`default_nettype wire

/* File: verilog/arc_fault_status_outputs.sv */
`default_nettype none
// Summary of operation
// - Arc detection drives the fault flag output high.
// - Fault flag is a static level able to drive a DC break switch.
// - Self-test malfunction report sets the fault flag high.
// - Failed final automatic recovery attempt sets the fault flag high.
// - Fault flag stays latched; only power cycle or host command clears.
// - Feature output pulses; positive width in ms carries arc features.
// - On malfunction the feature output stops at a constant level.
module arc_fault_status_outputs
    import fault_out_pkg::*;
#(
    parameter int unsigned CYC_MS   = CYC_PER_MS,
    parameter int unsigned W        = WIDTH_BITS,
    parameter int unsigned TRIES    = 3
) (
    input  wire logic         i_clk_sys,
    input  wire logic         i_nrst,
    input  wire logic         i_arc_detect,
    input  wire logic         i_self_test_fail,
    input  wire logic         i_recover_start,
    input  wire logic         i_recover_ok,
    input  wire logic         i_recover_fail,
    input  wire logic         i_host_clear,
    input  wire logic         i_halt_level,
    input  wire logic [W-1:0] i_width_ms,
    output logic              o_fault_flag_out,
    output logic              o_fault_flag_out_alias,
    output logic              o_feature_pulse_out,
    output logic              o_malfunction
);
    import fault_out_pkg::*;

    localparam int unsigned TW = $clog2(TRIES + 1);
    localparam logic [TW-1:0] TRY_LAST = TW'(TRIES);

    health_t       st_q;
    logic [TW-1:0] tries_q;
    logic          final_fail;
    logic          set_flag;

    assign final_fail = (st_q == ST_TRY) && i_recover_fail &&
                        (tries_q == TRY_LAST);
    assign set_flag   = i_arc_detect || final_fail ||
                        (i_self_test_fail && st_q == ST_RUN &&
                         TRIES == 0);

    // ****************************************************************
    // Self-test health and recovery
    // ****************************************************************
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            st_q    <= ST_RUN;
            tries_q <= '0;
        end else begin
            unique case (st_q)
                ST_RUN: begin
                    if (i_self_test_fail) begin
                        st_q    <= (TRIES == 0) ? ST_DEAD : ST_TRY;
                        tries_q <= '0;
                    end
                end
                ST_TRY: begin
                    if (i_recover_start && tries_q != TRY_LAST) begin
                        tries_q <= tries_q + 1'b1;
                    end else if (i_recover_ok && tries_q != '0) begin
                        st_q <= ST_RUN;
                    end else if (final_fail) begin
                        st_q <= ST_DEAD;
                    end
                end
                ST_DEAD: begin
                    if (i_host_clear) begin
                        st_q <= ST_RUN;
                    end
                end
                default: st_q <= ST_DEAD;
            endcase
        end
    end

    // ****************************************************************
    // Latched fault flag
    // ****************************************************************
    // Set wins over host clear so a coincident arc is never lost
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_fault_flag_out       <= FLAG_RST;
            o_fault_flag_out_alias <= FLAG_RST;
        end else if (set_flag || i_self_test_fail) begin
            o_fault_flag_out       <= 1'b1;
            o_fault_flag_out_alias <= 1'b1;
        end else if (i_host_clear) begin
            o_fault_flag_out       <= 1'b0;
            o_fault_flag_out_alias <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_malfunction <= 1'b0;
        end else begin
            o_malfunction <= (st_q != ST_RUN);
        end
    end

    // ****************************************************************
    // Feature pulse output
    // ****************************************************************
    // Halts during recovery too; a watchdog downstream sees the gap
    feature_pulse_gen #(
        .CYC_MS (CYC_MS),
        .W      (W),
        .PER    (W'(PERIOD_MS))
    ) u_pulse (
        .i_clk_sys  (i_clk_sys),
        .i_nrst     (i_nrst),
        .i_width_ms (i_width_ms),
        .i_halt     (st_q != ST_RUN),
        .i_halt_lvl (i_halt_level),
        .o_pulse    (o_feature_pulse_out)
    );

    // ****************************************************************
    // Rule checks
    // ****************************************************************
    property p_arc_sets;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        i_arc_detect |=> o_fault_flag_out;
    endproperty
    a_arc_sets: assert property (p_arc_sets)
        else $error("arc did not raise fault flag");

    property p_test_fail_sets;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        i_self_test_fail |=> o_fault_flag_out && o_fault_flag_out_alias;
    endproperty
    a_test_fail_sets: assert property (p_test_fail_sets)
        else $error("self-test failure did not raise fault flag");

    property p_final_fail;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        final_fail |=> o_fault_flag_out ##1 o_malfunction;
    endproperty
    a_final_fail: assert property (p_final_fail)
        else $error("final recovery failure not flagged");

    property p_latched;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        o_fault_flag_out && !i_host_clear |=> o_fault_flag_out;
    endproperty
    a_latched: assert property (p_latched)
        else $error("fault flag cleared without host command");

    // A clear in the very cycle of the rise is a legal host command
    property p_static;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        $rose(o_fault_flag_out) && !i_host_clear |-> o_fault_flag_out[*2];
    endproperty
    a_static: assert property (p_static)
        else $error("fault flag toggled");

    property p_alias;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        o_fault_flag_out == o_fault_flag_out_alias;
    endproperty
    a_alias: assert property (p_alias)
        else $error("fault flag copies differ");

    property p_no_rise_without_cause;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        $rose(o_fault_flag_out) |-> $past(set_flag || i_self_test_fail);
    endproperty
    a_no_rise_without_cause: assert property (p_no_rise_without_cause)
        else $error("fault flag rose with no cause");

    property p_halt_out;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        o_malfunction ##1 o_malfunction |-> $stable(o_feature_pulse_out);
    endproperty
    a_halt_out: assert property (p_halt_out)
        else $error("feature output moved during malfunction");

    property p_test_fail_halts;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        i_self_test_fail && st_q == ST_RUN |-> ##2 o_malfunction;
    endproperty
    a_test_fail_halts: assert property (p_test_fail_halts)
        else $error("self-test failure did not halt the pulses");

    property p_halt_level;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        o_malfunction |-> o_feature_pulse_out == $past(i_halt_level);
    endproperty
    a_halt_level: assert property (p_halt_level)
        else $error("feature output not at the halt level");

    property p_dead_holds;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        st_q == ST_DEAD && !i_host_clear |=> st_q == ST_DEAD;
    endproperty
    a_dead_holds: assert property (p_dead_holds)
        else $error("dead state left without host command");

    property p_fall_needs_clear;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        $fell(o_fault_flag_out) |-> $past(i_host_clear);
    endproperty
    a_fall_needs_clear: assert property (p_fall_needs_clear)
        else $error("fault flag fell without host command");

    property p_clear_works;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        i_host_clear && !set_flag && !i_self_test_fail |=> !o_fault_flag_out;
    endproperty
    a_clear_works: assert property (p_clear_works)
        else $error("host command did not clear fault flag");
endmodule
`default_nettype wire

/* File: verif/fault_monitor_model.sv */
`default_nettype none
module fault_monitor_model #(
    parameter int unsigned LIMIT = 2048
) (
    input  wire logic i_clk_sys,
    input  wire logic i_nrst,
    input  wire logic i_fault_flag,
    input  wire logic i_feature_pulse,
    output logic      o_break_open,
    output logic      o_pulse_lost
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned quiet_cnt;
    logic        last_q;
    // ****************************************************************
    // Break switch and pulse watchdog
    // ****************************************************************
    // A real break switch stays open until power is cycled
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_break_open <= 1'b0;
        end else if (i_fault_flag) begin
            o_break_open <= 1'b1;
        end
    end
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            last_q    <= 1'b0;
            quiet_cnt <= 0;
        end else begin
            last_q    <= i_feature_pulse;
            quiet_cnt <= (last_q != i_feature_pulse) ? 0 : quiet_cnt + 1;
        end
    end
    assign o_pulse_lost = (quiet_cnt > LIMIT);
endmodule
`default_nettype wire

/* File: verif/arc_fault_status_outputs_bench.sv */
`default_nettype none
module arc_fault_status_outputs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import fault_out_pkg::*;
    localparam int unsigned CMS = 4;
    localparam int unsigned NTRY = 3;
    localparam int unsigned PER = PERIOD_MS * CMS;
    localparam int unsigned LIM = 2 * PER;
    logic                  i_clk_sys = 1'b0;
    logic                  i_nrst    = 1'b0;
    logic [5:0]            ev        = '0;
    logic                  hlv       = 1'b0;
    logic [WIDTH_BITS-1:0] wid       = '0;
    logic                  flag, alias_f, pulse, malf, brk, lost;
    int                    error_cnt = 0;
    int                    n_compared = 0;
    int                    exp_flag = 0;
    int                    hi, bad;
    always #4 i_clk_sys = ~i_clk_sys;
    // ****************************************************************
    // Design and far side
    // ****************************************************************
    arc_fault_status_outputs #(.CYC_MS(CMS), .TRIES(NTRY))
        arc_fault_status_outputs_i (
        .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_arc_detect(ev[0]),
        .i_self_test_fail(ev[1]), .i_recover_start(ev[2]),
        .i_recover_ok(ev[3]), .i_recover_fail(ev[4]), .i_host_clear(ev[5]),
        .i_halt_level(hlv), .i_width_ms(wid), .o_fault_flag_out(flag),
        .o_fault_flag_out_alias(alias_f), .o_feature_pulse_out(pulse),
        .o_malfunction(malf));
    fault_monitor_model #(.LIMIT(LIM)) fault_monitor_model_i (
        .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_fault_flag(flag),
        .i_feature_pulse(pulse), .o_break_open(brk), .o_pulse_lost(lost));
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic step(int n);
        repeat (n) @(negedge i_clk_sys);
    endtask
    // Inputs are driven at the falling edge, one cycle wide, then one
    // idle edge so that two strobes never share a time step
    task automatic strobe(int k);
        ev = 6'(1 << k);
        step(1);
        ev = '0;
        if (k <= 1) exp_flag = 1;
        if (k == 5) exp_flag = 0;
        step(1);
    endtask
    task automatic chk_flag();
        check("fault flag", flag, exp_flag);
        check("fault flag copy", alias_f, exp_flag);
    endtask
    task automatic wait_lvl(logic lvl);
        int n;
        n = 0;
        while (pulse !== lvl && n < 3 * PER) begin
            step(1);
            n++;
        end
        if (n >= 3 * PER) check("pulse edge wait", 0, 1);
    endtask
    // Second rise after a width change is sure to carry the new width
    task automatic measure();
        wait_lvl(0);
        wait_lvl(1);
        wait_lvl(0);
        wait_lvl(1);
        hi = 0;
        while (pulse === 1'b1 && hi <= PER) begin
            step(1);
            hi++;
        end
        check("pulse width", hi, wid * CMS);
    endtask
    initial begin
        #640000;
        check("run time", 0, 1);
        give_verdict();
    end
    initial begin
        void'($urandom(32'h7CD00738));
        step(3);
        check("flag in reset", flag, 0);
        check("pulse in reset", pulse, 0);
        step(3);
        i_nrst = 1'b1;
        $display("test reset done");
        for (int i = 0; i < 3; i++) begin
            wid = (i == 0) ? 8'h01 : (i == 1) ? 8'hFE : 8'(1 + $urandom % 254);
            measure();
        end
        check("watchdog quiet", lost, 0);
        $display("test widths done");
        strobe(0);
        step(1);
        chk_flag();
        check("break open", brk, 1);
        step(50 + $urandom % 250);
        chk_flag();
        ev = 6'h21;
        step(1);
        ev = '0;
        step(1);
        chk_flag();
        strobe(5);
        step(1);
        chk_flag();
        $display("test arc done");
        hlv = 1'($urandom);
        for (int l = 0; l < 2; l++) begin
            strobe(1);
            step(1);
            chk_flag();
            step(2);
            check("malfunction", malf, 1);
            bad = 0;
            for (int c = 0; c < LIM + 8; c++) begin
                step(1);
                if (pulse !== hlv) bad++;
            end
            check("halt cycles off level", bad, 0);
            check("watchdog alarm", lost, 1);
            strobe(2);
            strobe(3);
            step(2);
            check("malfunction after ok", malf, 0);
            measure();
            chk_flag();
            strobe(5);
            step(1);
            chk_flag();
            hlv = ~hlv;
        end
        $display("test halt done");
        strobe(1);
        strobe(5);
        step(1);
        chk_flag();
        for (int a = 1; a <= NTRY; a++) begin
            strobe(2);
            strobe(4);
            if (a == NTRY) exp_flag = 1;
            step(2);
            chk_flag();
        end
        step(300);
        chk_flag();
        check("dead state", malf, 1);
        strobe(5);
        step(2);
        chk_flag();
        check("dead cleared", malf, 0);
        $display("test recovery done");
        strobe(0);
        chk_flag();
        i_nrst = 1'b0;
        exp_flag = 0;
        step(2);
        chk_flag();
        check("malfunction in reset", malf, 0);
        check("break in reset", brk, 0);
        i_nrst = 1'b1;
        step(3);
        chk_flag();
        $display("test power cycle done");
        give_verdict();
    end
endmodule
`default_nettype wire
